// ### hw/timer_wdt_ops_map.vh
`ifndef TIMER_WDT_OPS_MAP_VH
`define TIMER_WDT_OPS_MAP_VH

// register byte offsets
`define OFS_CTRL       4'h0
`define OFS_PRE_OPC    4'h4
`define OFS_STATUS     4'h8
`define OFS_VALUES     4'hc
`define ADDR_LSB       2
`define ADDR_HI        3

// ctrl fields
`define CTRL_STOP_ALLOW 0
`define CTRL_RST        1'h1

// pre-opcode register
`define PRE_OPC_RST    10'h000

// status fields
`define ST_FLAG        0
`define ST_STOP        1
`define ST_SKIP        2
`define ST_LAST_PRE    3
`define ST_SKIP_CNT_LO 8
`define ST_SKIP_CNT_HI 15

// values fields
`define VAL_CTL5_LO    0
`define VAL_CTL6_LO    4
`define VAL_PTR_Y_LO   8

// reset values of core-visible registers
`define NIBBLE_RST     4'h0
`define SKIP_CNT_RST   8'h00

// instruction codes
`define OPC_TW5        10'h212
`define OPC_TW6        10'h213
`define OPC_WATCHDOG_RESTART_OP       10'h2a0
`define OPC_PTR_Y_DEF  10'h0c0

// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### hw/op_decode.v
`timescale 1ns/1ps
`include "timer_wdt_ops_map.vh"

// matches the current opcode against the instructions this block executes
module op_decode
(
  input  wire [9:0] opcode,
  input  wire [9:0] pre_opcode,
  input  wire [9:0] ptr_y_opcode,
  output wire       hit_ctl5,
  output wire       hit_ctl6,
  output wire       hit_ptr_y,
  output wire       hit_watchdog_restart_op,
  output wire       hit_pre
);

  // exact compare of a full 10-bit code
  function match;
    input [9:0] a;
    input [9:0] b;
    begin
      match = (a == b);
    end
  endfunction

  // one hit line per instruction
  assign hit_ctl5  = match(opcode, `OPC_TW5);
  assign hit_ctl6  = match(opcode, `OPC_TW6);
  assign hit_ptr_y = match(opcode, ptr_y_opcode);
  assign hit_watchdog_restart_op  = match(opcode, `OPC_WATCHDOG_RESTART_OP);
  assign hit_pre   = match(opcode, pre_opcode);

endmodule

// ### hw/wdt_flag_cell.v
`timescale 1ns/1ps

// watchdog expiry flag: set by the watchdog, cleared by the restart op
module wdt_flag_cell
(
  input  wire aclk,
  input  wire aresetn,
  input  wire set_evt,
  input  wire clr_req,
  output reg  flag
);

  // a set in the clearing cycle wins so no expiry is lost
  always @(posedge aclk)
  begin
    if (!aresetn)
      flag <= 1'b0;
    else if (set_evt)
      flag <= 1'b1;
    else if (clr_req)
      flag <= 1'b0;
  end

endmodule

// ### hw/timer_wdt_transfer_ops.v
// Behaviour
// - code 0x212 copies accumulator to ctl5
// - code 0x213 copies accumulator to ctl6
// - pointer transfer loads Y from accumulator
// - restart op: flag set clears it, skips
// - restart op with flag clear: no skip
// - restart after designated op stops watchdog
`timescale 1ns/1ps
`include "timer_wdt_ops_map.vh"

module timer_wdt_transfer_ops
#(
  parameter [9:0] PTR_Y_OPCODE = `OPC_PTR_Y_DEF
)
(
  input  wire        aclk,
  input  wire        aresetn,
  // instruction stream from the core
  input  wire        exec_valid,
  input  wire [9:0]  opcode,
  input  wire [3:0]  acc,
  // watchdog hardware
  input  wire        wdt_expired,
  output wire        watchdog_expiry_flag,
  output reg         watchdog_stop,
  // results towards the core and timers
  output reg  [3:0]  timer_ctl_five,
  output reg  [3:0]  timer_ctl_six,
  output reg  [3:0]  ptr_y,
  output reg         timer_ctl_five_we,
  output reg         timer_ctl_six_we,
  output reg         ptr_y_we,
  output reg         skip_pending,
  output reg         instr_skipped,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // software control state
  reg        stop_allow;
  reg  [9:0] pre_opcode;

  // execution state
  reg        last_was_pre;
  reg  [7:0] skip_cnt;

  // write channel holding registers
  reg        aw_held;
  reg  [3:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg  [3:0] w_strb;

  // decoder hits
  wire hit_ctl5;
  wire hit_ctl6;
  wire hit_ptr_y;
  wire hit_watchdog_restart_op;
  wire hit_pre;

  // execute vs. discard of the current instruction word
  wire run;
  wire drop;
  wire watchdog_restart_op_run;
  wire watchdog_restart_op_skip;
  wire wr_fire;
  wire ar_fire;

  // true for the four mapped word offsets
  function addr_known;
    input [3:0] a;
    begin
      addr_known = (a == `OFS_CTRL) || (a == `OFS_PRE_OPC) ||
                   (a == `OFS_STATUS) || (a == `OFS_VALUES);
    end
  endfunction

  // true for offsets software may write
  function addr_writable;
    input [3:0] a;
    begin
      addr_writable = (a == `OFS_CTRL) || (a == `OFS_PRE_OPC);
    end
  endfunction

  // opcode matching
  op_decode u_decode
  (
    .opcode       (opcode),
    .pre_opcode   (pre_opcode),
    .ptr_y_opcode (PTR_Y_OPCODE),
    .hit_ctl5     (hit_ctl5),
    .hit_ctl6     (hit_ctl6),
    .hit_ptr_y    (hit_ptr_y),
    .hit_watchdog_restart_op     (hit_watchdog_restart_op),
    .hit_pre      (hit_pre)
  );

  // an instruction runs only when no skip is owed
  assign run       = exec_valid && !skip_pending;
  assign drop      = exec_valid && skip_pending;
  assign watchdog_restart_op_run  = run && hit_watchdog_restart_op;
  assign watchdog_restart_op_skip = watchdog_restart_op_run && watchdog_expiry_flag;

  // watchdog expiry flag, test-and-clear by the restart op
  wdt_flag_cell u_flag
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_evt (wdt_expired),
    .clr_req (watchdog_restart_op_skip),
    .flag    (watchdog_expiry_flag)
  );

  // accumulator transfers into timer control and pointer registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_ctl_five    <= `NIBBLE_RST;
      timer_ctl_six     <= `NIBBLE_RST;
      ptr_y             <= `NIBBLE_RST;
      timer_ctl_five_we <= 1'b0;
      timer_ctl_six_we  <= 1'b0;
      ptr_y_we          <= 1'b0;
    end
    else
    begin
      timer_ctl_five_we <= run && hit_ctl5;
      timer_ctl_six_we  <= run && hit_ctl6;
      ptr_y_we          <= run && hit_ptr_y;
      if (run && hit_ctl5)
        timer_ctl_five <= acc;
      if (run && hit_ctl6)
        timer_ctl_six <= acc;
      if (run && hit_ptr_y)
        ptr_y <= acc;
    end
  end

  // skip bookkeeping: owed skip is consumed by the next word
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      skip_pending  <= 1'b0;
      instr_skipped <= 1'b0;
      skip_cnt      <= `SKIP_CNT_RST;
    end
    else
    begin
      instr_skipped <= drop;
      if (exec_valid)
        skip_pending <= watchdog_restart_op_skip;
      if (drop)
        skip_cnt <= skip_cnt + 8'h01;
    end
  end

  // remembers whether the last valid word was the designated op and ran (a skipped word clears it)
  always @(posedge aclk)
  begin
    if (!aresetn)
      last_was_pre <= 1'b0;
    else if (exec_valid)
      last_was_pre <= run && hit_pre;
  end

  // watchdog stop, held until reset
  always @(posedge aclk)
  begin
    if (!aresetn)
      watchdog_stop <= 1'b0;
    else if (watchdog_restart_op_run && last_was_pre && stop_allow)
      watchdog_stop <= 1'b1;
  end

  // write address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // capture of write channels
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // register writes honour byte strobes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stop_allow <= `CTRL_RST;
      pre_opcode <= `PRE_OPC_RST;
    end
    else if (wr_fire)
    begin
      if (aw_addr == `OFS_CTRL && w_strb[0])
        stop_allow <= w_data[`CTRL_STOP_ALLOW];
      if (aw_addr == `OFS_PRE_OPC && w_strb[0])
        pre_opcode[7:0] <= w_data[7:0];
      if (aw_addr == `OFS_PRE_OPC && w_strb[1])
        pre_opcode[9:8] <= w_data[9:8];
    end
  end

  // write response: okay for writable words, slverr otherwise
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_writable(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel: one read at a time
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  // read data mux, registered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `OFS_CTRL:
          s_axi_rdata[`CTRL_STOP_ALLOW] <= stop_allow;
        `OFS_PRE_OPC:
          s_axi_rdata[9:0] <= pre_opcode;
        `OFS_STATUS:
        begin
          s_axi_rdata[`ST_FLAG]     <= watchdog_expiry_flag;
          s_axi_rdata[`ST_STOP]     <= watchdog_stop;
          s_axi_rdata[`ST_SKIP]     <= skip_pending;
          s_axi_rdata[`ST_LAST_PRE] <= last_was_pre;
          s_axi_rdata[`ST_SKIP_CNT_HI:`ST_SKIP_CNT_LO] <= skip_cnt;
        end
        `OFS_VALUES:
        begin
          s_axi_rdata[`VAL_CTL5_LO+3:`VAL_CTL5_LO]   <= timer_ctl_five;
          s_axi_rdata[`VAL_CTL6_LO+3:`VAL_CTL6_LO]   <= timer_ctl_six;
          s_axi_rdata[`VAL_PTR_Y_LO+3:`VAL_PTR_Y_LO] <= ptr_y;
        end
        default:
          s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ### sim/timer_wdt_transfer_ops_chk.sv
`timescale 1ns/1ps
`include "timer_wdt_ops_map.vh"
module timer_wdt_transfer_ops_chk
#(
  parameter [9:0] PTR_Y_OPCODE = `OPC_PTR_Y_DEF
)
(
  input logic       aclk,
  input logic       aresetn,
  input logic       exec_valid,
  input logic [9:0] opcode,
  input logic [3:0] acc,
  input logic       wdt_expired,
  input logic       watchdog_expiry_flag,
  input logic       watchdog_stop,
  input logic [3:0] timer_ctl_five,
  input logic [3:0] timer_ctl_six,
  input logic [3:0] ptr_y,
  input logic       skip_pending,
  input logic       instr_skipped
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // words that really execute
  wire run = exec_valid && !skip_pending;
  wire watchdog_restart_op_run = run && opcode == `OPC_WATCHDOG_RESTART_OP;
  wire flag = watchdog_expiry_flag;
  property p_ctl5; run && opcode == `OPC_TW5 |=> timer_ctl_five == $past(acc); endproperty
  a_ctl5: assert property (p_ctl5) else $error("ctl5 load");
  property p_hold5; !(run && opcode == `OPC_TW5) |=> $stable(timer_ctl_five); endproperty
  a_hold5: assert property (p_hold5) else $error("ctl5 moved");
  property p_ctl6;
    run && opcode == `OPC_TW6 |=> timer_ctl_six == $past(acc) && !skip_pending;
  endproperty
  a_ctl6: assert property (p_ctl6) else $error("ctl6 load");
  property p_ptr; run && opcode == PTR_Y_OPCODE |=> ptr_y == $past(acc); endproperty
  a_ptr: assert property (p_ptr) else $error("ptr_y load");
  property p_clr; watchdog_restart_op_run && flag && !wdt_expired |=> !flag && skip_pending; endproperty
  a_clr: assert property (p_clr) else $error("flag clear or skip");
  property p_noskip; watchdog_restart_op_run && !flag |=> !skip_pending; endproperty
  a_noskip: assert property (p_noskip) else $error("unwanted skip");
  property p_nop;
    exec_valid && skip_pending |=> instr_skipped && !skip_pending && $stable(timer_ctl_five)
      && $stable(timer_ctl_six) && $stable(ptr_y);
  endproperty
  a_nop: assert property (p_nop) else $error("skipped word acted");
  property p_stop; $rose(watchdog_stop) |-> $past(watchdog_restart_op_run); endproperty
  a_stop: assert property (p_stop) else $error("stop without restart");
  property p_stay; watchdog_stop |=> watchdog_stop; endproperty
  a_stay: assert property (p_stay) else $error("stop dropped");
  c_skip: cover property (watchdog_restart_op_run && flag);
  c_stop: cover property ($rose(watchdog_stop));
  c_nop: cover property (instr_skipped);
endmodule
bind timer_wdt_transfer_ops timer_wdt_transfer_ops_chk #(.PTR_Y_OPCODE(PTR_Y_OPCODE)) u_chk (.*);

// ### sim/tb.sv
`timescale 1ns/1ps
`include "timer_wdt_ops_map.vh"
module tb;
  logic        aclk = 1'h0, aresetn = 1'h0, exec_valid = 1'h0, wdt_expired = 1'h0;
  logic [9:0]  opcode = 10'h0;
  logic [3:0]  acc = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0]  rs;
  wire         watchdog_expiry_flag, watchdog_stop, timer_ctl_five_we, timer_ctl_six_we;
  wire         ptr_y_we, skip_pending, instr_skipped, s_axi_awready, s_axi_wready;
  wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [3:0]   timer_ctl_five, timer_ctl_six, ptr_y;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  integer      miscompares = 0, check_count = 0;
  timer_wdt_transfer_ops u_timer_wdt_transfer_ops (.*);
  // 20 mhz clock
  always #25 aclk = ~aclk;
  task check(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one instruction word per edge
  task issue(input [9:0] op, input [3:0] a);
    @(posedge aclk);
    exec_valid <= 1'h1;
    opcode <= op;
    acc <= a;
  endtask
  task idle;
    @(posedge aclk);
    exec_valid <= 1'h0;
    #1;
  endtask
  // readies sampled before the edge, released after it
  task axi_wr(input [3:0] a, input [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task axi_rd(input [3:0] a);
    logic ar, b;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(negedge aclk);
      ar = s_axi_arready;
      b = s_axi_rvalid;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  // reset values
  task t_reset;
    check({timer_ctl_five, timer_ctl_six, ptr_y, watchdog_stop}, 13'h0);
    axi_rd(`OFS_CTRL);
    check(rd, 32'h1);
    axi_rd(`OFS_PRE_OPC);
    check(rd, 32'h0);
  endtask
  // back-to-back transfers
  task t_xfer;
    issue(`OPC_TW5, 4'h5);
    issue(`OPC_TW6, 4'ha);
    #1;
    check({timer_ctl_five_we, timer_ctl_six_we, ptr_y_we}, 3'h4);
    issue(`OPC_PTR_Y_DEF, 4'h3);
    #1;
    check({timer_ctl_five_we, timer_ctl_six_we, ptr_y_we}, 3'h2);
    idle;
    check({timer_ctl_five_we, timer_ctl_six_we, ptr_y_we}, 3'h1);
    check(timer_ctl_five, 4'h5);
    check({timer_ctl_six, skip_pending}, 5'h14);
    check(ptr_y, 4'h3);
    axi_rd(`OFS_VALUES);
    check(rd, 32'h3a5);
  endtask
  // flag set: clear and skip the next word
  task t_skip;
    @(posedge aclk);
    wdt_expired <= 1'h1;
    @(posedge aclk);
    wdt_expired <= 1'h0;
    #1;
    check(watchdog_expiry_flag, 1'h1);
    issue(`OPC_WATCHDOG_RESTART_OP, 4'h0);
    issue(`OPC_TW5, 4'hf);
    #1;
    check({watchdog_expiry_flag, skip_pending}, 2'h1);
    issue(`OPC_TW5, 4'h9);
    #1;
    check({instr_skipped, timer_ctl_five_we, timer_ctl_five}, 6'h25);
    idle;
    check(timer_ctl_five, 4'h9);
    axi_rd(`OFS_STATUS);
    check(rd[15:8], 8'h1);
  endtask
  // flag clear: next word runs
  task t_noskip;
    issue(`OPC_WATCHDOG_RESTART_OP, 4'h0);
    issue(`OPC_TW6, 4'hc);
    idle;
    check({timer_ctl_six, skip_pending}, 5'h18);
  endtask
  // stop only right after the designated word
  task t_stop;
    axi_wr(`OFS_CTRL, 32'h0);
    check(rs, `RESP_OKAY);
    axi_rd(`OFS_CTRL);
    check(rd, 32'h0);
    axi_wr(`OFS_PRE_OPC, {22'h0, `OPC_TW6});
    check(rs, `RESP_OKAY);
    // stop not allowed: adjacent pair leaves watchdog running
    issue(`OPC_TW6, 4'h1);
    issue(`OPC_WATCHDOG_RESTART_OP, 4'h0);
    idle;
    check(watchdog_stop, 1'h0);
    axi_wr(`OFS_CTRL, 32'h1);
    check(rs, `RESP_OKAY);
    issue(`OPC_TW6, 4'h1);
    issue(`OPC_TW5, 4'h2);
    issue(`OPC_WATCHDOG_RESTART_OP, 4'h0);
    idle;
    check(watchdog_stop, 1'h0);
    issue(`OPC_TW6, 4'h3);
    issue(`OPC_WATCHDOG_RESTART_OP, 4'h0);
    idle;
    check(watchdog_stop, 1'h1);
    axi_wr(`OFS_VALUES, 32'h0);
    check(rs, `RESP_SLVERR);
    axi_rd(`OFS_VALUES);
    check(rd, 32'h332);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    #1;
    t_reset;
    t_xfer;
    t_skip;
    t_noskip;
    t_stop;
    report_and_stop;
  end
  // hang guard
  initial
  begin
    repeat (2000) @(posedge aclk);
    miscompares++;
    report_and_stop;
  end
endmodule
